// [inc/gpd_regs.svh]
// Purpose: register offsets, field positions, reset values of the dual gpio port
// Assumes: indices are word indices, byte address = 4 * index
// Notes:   definitions only
`ifndef GPD_REGS_SVH
`define GPD_REGS_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define GPD_IDX_A_DATA   8'h05
`define GPD_IDX_B_DATA   8'h06
`define GPD_IDX_OPTION   8'h81
`define GPD_IDX_A_DIR    8'h85
`define GPD_IDX_B_DIR    8'h86
`define GPD_IDX_ANALOG   8'h9f
`define GPD_IDX_INTCTL   8'ha0

// ----------------------------------------
// field positions
// ----------------------------------------
`define GPD_BIT_PULLUP_N 7
`define GPD_BIT_EDGE_SEL 6
`define GPD_BIT_CHG_FLAG 0
`define GPD_BIT_EXT_FLAG 1
`define GPD_BIT_A_INONLY 5

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define GPD_RST_DIR      8'hff
`define GPD_RST_OPTION   8'hff
`define GPD_RST_ANALOG   8'h00
`define GPD_RST_LATCH    8'h00
`define GPD_ANALOG_WMASK 8'hcf
`define GPD_ANALOG_ALLD  3'h3
`define GPD_RESP_OKAY    2'h0
`define GPD_RESP_SLVERR  2'h2

`endif

// [inc/gpd_pkg.sv]
// Purpose: types shared by the dual gpio port files
// Assumes: nothing
// Notes:   offsets live in gpd_regs.svh
package gpd_pkg;
    // one register write handed from the bus front end
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] data;
        logic       strb;
    } gpd_wr_s;

    // read channel state, one-hot
    typedef enum logic [2:0] {
        RD_IDLE  = 3'b001,
        RD_FETCH = 3'b010,
        RD_RESP  = 3'b100
    } gpd_rd_e;
endpackage

// [hw/gpd_axil_slave.sv]
// Purpose: axi4-lite slave front end, turns bus beats into register strobes
// Assumes: one write and one read outstanding at most
// Notes:   decode and read data come back from the parent combinationally
`timescale 1ns/1ps
`default_nettype none
`include "gpd_regs.svh"

module gpd_axil_slave
    import gpd_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rstN,
    input  wire logic [9:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [9:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output gpd_wr_s          wrReq,
    output logic             wrFire,
    input  wire logic        wrHit,
    output logic [7:0]       rdIdx,
    output logic             rdFire,
    input  wire logic [7:0]  rdData,
    input  wire logic        rdHit
);
    // ----------------------------------------
    // write channel
    // ----------------------------------------
    logic    awHeld;            // address taken, not yet used
    logic    wHeld;             // data taken, not yet used
    gpd_rd_e rdState;           // read sequencer
    wire awTake = awvalid & awready;
    wire wTake  = wvalid & wready;
    wire bDone  = bvalid & bready;

    assign wrFire = awHeld & wHeld;

    // capture address and data in either order
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            awHeld  <= 1'b0;
            wHeld   <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= `GPD_RESP_OKAY;
            wrReq   <= '0;
        end else begin
            if (awTake) begin
                awready   <= 1'b0;
                awHeld    <= 1'b1;
                wrReq.idx <= awaddr[9:2];
            end
            if (wTake) begin
                wready     <= 1'b0;
                wHeld      <= 1'b1;
                wrReq.data <= wdata[7:0];
                wrReq.strb <= wstrb[0];
            end
            if (wrFire) begin       // register updated this cycle
                awHeld <= 1'b0;
                wHeld  <= 1'b0;
                bvalid <= 1'b1;
                bresp  <= wrHit ? `GPD_RESP_OKAY : `GPD_RESP_SLVERR;
            end
            if (bDone) begin        // reopen both channels
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    assign arready = rdState[0];
    assign rdFire  = rdState[1];

    // take address, fetch one cycle, answer
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            rdState <= RD_IDLE;
            rdIdx   <= 8'h00;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `GPD_RESP_OKAY;
        end else begin
            case (rdState)
                RD_IDLE: begin
                    if (arvalid) begin
                        rdIdx   <= araddr[9:2];
                        rdState <= RD_FETCH;
                    end
                end
                RD_FETCH: begin
                    rdata   <= {24'h00_0000, rdData};
                    rresp   <= rdHit ? `GPD_RESP_OKAY : `GPD_RESP_SLVERR;
                    rvalid  <= 1'b1;
                    rdState <= RD_RESP;
                end
                RD_RESP: begin
                    if (rready) begin
                        rvalid  <= 1'b0;
                        rdState <= RD_IDLE;
                    end
                end
                default: rdState <= RD_IDLE;
            endcase
        end
    end
endmodule

`default_nettype wire

// [hw/gpd_port_top.sv]
// Purpose: two 8-bit bidirectional gpio ports with change detect and ext irq
// Assumes: pins are asynchronous, registers reached over axi4-lite
// Notes:   pin drive, enables and pull-ups are registered, one cycle late
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "gpd_regs.svh"

module gpd_port_top
    import gpd_pkg::*;
#(
    parameter int PORT_W = 8        // bits per port
)
(
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic [9:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [9:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic [PORT_W-1:0] portAIn,
    output logic [PORT_W-1:0]      portAOut,
    output logic [PORT_W-1:0]      portAOe,
    input  wire logic [PORT_W-1:0] portBIn,
    output logic [PORT_W-1:0]      portBOut,
    output logic [PORT_W-1:0]      portBOe,
    output logic [PORT_W-1:0]      portBPullup,
    input  wire logic [PORT_W-1:0] periphOwnB,
    input  wire logic [PORT_W-1:0] periphDirB,
    input  wire logic              oscOwnsA,
    output logic                   portChangeFlag,
    output logic                   extIrqFlag,
    output logic                   wakeRequest
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rstPipe;            // release synchroniser
    wire        rstN = rstPipe[1];  // design reset

    // two flops on the release edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [PORT_W-1:0] aMeta;       // first stage, port a
    logic [PORT_W-1:0] aSync;       // port a pin levels
    logic [PORT_W-1:0] bMeta;       // first stage, port b
    logic [PORT_W-1:0] bSync;       // port b pin levels
    logic              b0Prev;      // b0 one cycle older
    logic [2:0]        primed;      // sync chain filled, no false edge

    // input buffer thresholds are pad cells; logic sees clean levels
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            aMeta  <= '0;
            aSync  <= '0;
            bMeta  <= '0;
            bSync  <= '0;
            b0Prev <= 1'b0;
            primed <= 3'h0;
        end else begin
            aMeta  <= portAIn;
            aSync  <= aMeta;
            bMeta  <= portBIn;
            bSync  <= bMeta;
            b0Prev <= bSync[0];
            primed <= {primed[1:0], 1'b1};
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [PORT_W-1:0] latchA;      // port a output latch
    logic [PORT_W-1:0] latchB;      // port b output latch
    logic [PORT_W-1:0] dirA;        // port a direction
    logic [PORT_W-1:0] dirB;        // port b direction
    logic [7:0]        optionReg;   // pull-up and edge controls
    logic [7:0]        analogCfg;   // analog pin configuration
    logic [3:0]        refB;        // upper nibble reference
    gpd_wr_s           wrReq;       // write from bus
    logic              wrFire;      // write strobe
    logic [7:0]        rdIdx;       // read index
    logic              rdFire;      // read strobe

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire hitAData  = wrReq.idx == `GPD_IDX_A_DATA;
    wire hitBData  = wrReq.idx == `GPD_IDX_B_DATA;
    wire hitOption = wrReq.idx == `GPD_IDX_OPTION;
    wire hitADir   = wrReq.idx == `GPD_IDX_A_DIR;
    wire hitBDir   = wrReq.idx == `GPD_IDX_B_DIR;
    wire hitAnalog = wrReq.idx == `GPD_IDX_ANALOG;
    wire hitIntctl = wrReq.idx == `GPD_IDX_INTCTL;
    wire wrHit     = hitAData | hitBData | hitOption | hitADir
                   | hitBDir | hitAnalog | hitIntctl;
    wire rdB       = rdFire & (rdIdx == `GPD_IDX_B_DATA);
    wire wrB       = wrFire & hitBData;

    // pcfg low code 011x makes all pins digital, else a4..a0 analog
    wire       allDigital = analogCfg[3:1] == `GPD_ANALOG_ALLD;
    wire [4:0] anaMask    = allDigital ? 5'h00 : 5'h1f;

    // port a reads: analog pins 0, bit 5 always pin
    wire [PORT_W-1:0] pinsA = aSync & ~{{(PORT_W-5){1'b0}}, anaMask};
    wire [PORT_W-1:0] pinsB = bSync;

    // direction bit 5 reads 1 whatever was written
    wire [PORT_W-1:0] dirARead = dirA | (8'h01 << `GPD_BIT_A_INONLY);

    // read-modify-write: unstrobed byte keeps pin levels
    wire [PORT_W-1:0] mergeA = wrReq.strb ? wrReq.data : pinsA;
    wire [PORT_W-1:0] mergeB = wrReq.strb ? wrReq.data : pinsB;

    // read data selection
    logic [7:0] rdData;
    wire [7:0] intctlRead = {6'h00, extIrqFlag, portChangeFlag};
    wire rdHit = (rdIdx == `GPD_IDX_A_DATA) | (rdIdx == `GPD_IDX_B_DATA)
               | (rdIdx == `GPD_IDX_OPTION) | (rdIdx == `GPD_IDX_A_DIR)
               | (rdIdx == `GPD_IDX_B_DIR) | (rdIdx == `GPD_IDX_ANALOG)
               | (rdIdx == `GPD_IDX_INTCTL);
    assign rdData = (rdIdx == `GPD_IDX_A_DATA) ? pinsA :
                    (rdIdx == `GPD_IDX_B_DATA) ? pinsB :
                    (rdIdx == `GPD_IDX_OPTION) ? optionReg :
                    (rdIdx == `GPD_IDX_A_DIR)  ? dirARead :
                    (rdIdx == `GPD_IDX_B_DIR)  ? dirB :
                    (rdIdx == `GPD_IDX_ANALOG) ? analogCfg :
                    (rdIdx == `GPD_IDX_INTCTL) ? intctlRead : 8'h00;

    // ----------------------------------------
    // effective directions
    // ----------------------------------------
    // peripheral ownership replaces the software direction
    wire [PORT_W-1:0] dirBEff = (dirB & ~periphOwnB) | (periphDirB & periphOwnB);
    // oscillator pins float when the oscillator owns them
    wire [PORT_W-1:0] dirAEff = dirARead | {oscOwnsA, oscOwnsA, 6'h00};

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    // latches take the merged byte on every data write
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            latchA    <= `GPD_RST_LATCH;
            latchB    <= `GPD_RST_LATCH;
            dirA      <= `GPD_RST_DIR;
            dirB      <= `GPD_RST_DIR;
            optionReg <= `GPD_RST_OPTION;    // pull-ups off
            analogCfg <= `GPD_RST_ANALOG;    // a4..a0 analog
        end else if (wrFire) begin
            if (hitAData) latchA <= mergeA;
            if (hitBData) latchB <= mergeB;
            if (hitADir && wrReq.strb) dirA <= wrReq.data;
            if (hitBDir && wrReq.strb) dirB <= wrReq.data;
            if (hitOption && wrReq.strb) optionReg <= wrReq.data;
            if (hitAnalog && wrReq.strb) begin
                analogCfg <= wrReq.data & `GPD_ANALOG_WMASK;
            end
        end
    end

    // ----------------------------------------
    // change detection
    // ----------------------------------------
    // only upper-nibble inputs take part
    wire [3:0] chgMis   = (pinsB[7:4] ^ refB) & dirBEff[7:4];
    wire       mismatch = |chgMis;
    wire       clrChg   = wrFire & hitIntctl & wrReq.strb
                        & ~wrReq.data[`GPD_BIT_CHG_FLAG];
    wire       clrExt   = wrFire & hitIntctl & wrReq.strb
                        & ~wrReq.data[`GPD_BIT_EXT_FLAG];
    // active edge: option bit 6 high selects rising
    wire       edgeSel  = optionReg[`GPD_BIT_EDGE_SEL];
    // no edge until sync and history hold real pin levels after reset
    wire       rawEdge  = edgeSel ? (bSync[0] & ~b0Prev) : (~bSync[0] & b0Prev);
    wire       extEdge  = primed[2] & rawEdge;

    // reference reloads on any port b access
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            refB <= 4'h0;
        end else if (rdB || wrB) begin
            refB <= pinsB[7:4];
        end
    end

    // sticky flags; setting beats clearing
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            portChangeFlag <= 1'b0;
            extIrqFlag     <= 1'b0;
            wakeRequest    <= 1'b0;
        end else begin
            portChangeFlag <= mismatch | (portChangeFlag & ~clrChg);
            extIrqFlag     <= extEdge | (extIrqFlag & ~clrExt);
            wakeRequest    <= mismatch | portChangeFlag;
        end
    end

    // ----------------------------------------
    // pin drive, one generate per bit
    // ----------------------------------------
    wire pullEnN = optionReg[`GPD_BIT_PULLUP_N];
    logic [PORT_W-1:0] next_aOe;
    logic [PORT_W-1:0] next_bOe;
    logic [PORT_W-1:0] next_pull;

    for (genvar i = 0; i < PORT_W; i++) begin : g_bit
        // direction 0 drives the latch, 1 floats
        assign next_aOe[i]  = ~dirAEff[i];
        assign next_bOe[i]  = ~dirBEff[i];
        // global enable, forced off on outputs
        assign next_pull[i] = ~pullEnN & dirBEff[i];
    end

    // registered pad controls
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            portAOut    <= '0;
            portAOe     <= '0;
            portBOut    <= '0;
            portBOe     <= '0;
            portBPullup <= '0;
        end else begin
            portAOut    <= latchA;
            portAOe     <= next_aOe;
            portBOut    <= latchB;
            portBOe     <= next_bOe;
            portBPullup <= next_pull;
        end
    end

    // ----------------------------------------
    // bus front end
    // ----------------------------------------
    gpd_axil_slave u_bus (
        .clock   (clock),
        .rstN    (rstN),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wrReq   (wrReq),
        .wrFire  (wrFire),
        .wrHit   (wrHit),
        .rdIdx   (rdIdx),
        .rdFire  (rdFire),
        .rdData  (rdData),
        .rdHit   (rdHit)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstN);

    sequence s_bwrite;
        wrFire && hitBData && !wrReq.strb;
    endsequence

    sequence s_chg_clear;
        clrChg && mismatch;
    endsequence

    a_pin5_never_out: assert property (!portAOe[5])
        else $error("port a bit 5 driven");
    a_dir5_reads_one: assert property (rdFire && rdIdx == `GPD_IDX_A_DIR |-> rdData[5])
        else $error("dir bit 5 read as 0");
    a_dir_sets_oe: assert property (##1 portBOe == ~$past(dirBEff))
        else $error("port b enable not from direction");
    a_pullup_outputs: assert property ((portBPullup & portBOe) == 8'h00)
        else $error("pull-up on while driving");
    a_pullup_reset: assert property ($rose(rstN) |-> portBPullup == 8'h00)
        else $error("pull-up on after reset");
    a_rmw_keeps_pins: assert property (s_bwrite |=> latchB == $past(pinsB))
        else $error("port b write lost pin levels");
    a_ref_refresh: assert property (rdB |=> refB == $past(pinsB[7:4]))
        else $error("reference not reloaded on read");
    a_flag_resets: assert property (s_chg_clear |=> portChangeFlag)
        else $error("flag cleared during mismatch");
    a_outputs_ignored: assert property (
        (((pinsB[7:4] ^ refB) & dirBEff[7:4]) == 4'h0) && !portChangeFlag
        |=> !portChangeFlag)
        else $error("output pin in comparison");
    a_ext_edge_flag: assert property (extEdge |=> extIrqFlag)
        else $error("edge missed");
    a_analog_zero: assert property (
        rdFire && rdIdx == `GPD_IDX_A_DATA && !allDigital |-> rdData[4:0] == 5'h00)
        else $error("analog pin read nonzero");
    a_wake_follows: assert property (portChangeFlag |=> wakeRequest)
        else $error("no wake on change flag");
endmodule

`default_nettype wire

// [tb/gpd_pin_model.sv]
// Purpose: pad and board model for one port
// Assumes: board drives every pin that the design leaves free
// Notes:   a free pin with no drive and no pull-up shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none

module gpd_pin_model (
    input  wire logic       clock,
    input  wire logic [7:0] out,
    input  wire logic [7:0] oe,
    input  wire logic [7:0] pu,
    input  wire logic [7:0] ext,
    input  wire logic [7:0] extEn,
    output logic      [7:0] pin
);
    logic [7:0] last = 8'h00;  // level seen one cycle ago

    // design drive wins, then board, then pull-up, else drift
    assign pin = (oe & out) | (~oe & extEn & ext) | (~oe & ~extEn & (pu | ~last));

    // remember the level for the drift pattern
    always_ff @(posedge clock) begin
        last <= pin;
    end
endmodule

`default_nettype wire

// [tb/tb_gpd_port_top.sv]
// Purpose: register and pin level bench of the dual port
// Assumes: board drives all port pins not driven by the design
// Notes:   flags are sampled a fixed few cycles after a pin change
`timescale 1ns/1ps
`default_nettype none
`include "gpd_regs.svh"

module tb_gpd_port_top;
    import gpd_pkg::*;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, oscOwnsA = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        portChangeFlag, extIrqFlag, wakeRequest;
    logic [1:0]  bresp, rresp;
    logic [7:0]  portAIn, portAOut, portAOe, portBIn, portBOut, portBOe, portBPullup;
    logic [7:0]  bExt = 8'h01, periphOwnB = 8'h00, periphDirB = 8'h00;
    int          miscompares = 0;
    int          checksDone = 0;

    always #12.5 clock = ~clock;

    gpd_port_top i_dut (.clock(clock), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .portAIn(portAIn), .portAOut(portAOut),
        .portAOe(portAOe), .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe),
        .portBPullup(portBPullup), .periphOwnB(periphOwnB), .periphDirB(periphDirB),
        .oscOwnsA(oscOwnsA), .portChangeFlag(portChangeFlag), .extIrqFlag(extIrqFlag),
        .wakeRequest(wakeRequest));
    gpd_pin_model i_pinA (.clock(clock), .out(portAOut), .oe(portAOe), .pu(8'h00),
        .ext(8'hff), .extEn(8'hff), .pin(portAIn));
    gpd_pin_model i_pinB (.clock(clock), .out(portBOut), .oe(portBOe), .pu(portBPullup),
        .ext(bExt), .extEn(8'hff), .pin(portBIn));

    // compare one value, count and report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic giveVerdict;
        if (miscompares == 0 && checksDone > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // axi4-lite write, address and data offered together
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic s = 1'b1,
                      input logic [1:0] er = `GPD_RESP_OKAY);
        bit done;
        done = 0;
        @(posedge clock);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        wstrb <= {3'h0, s};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                check(bresp, er);
                done = 1;
                bready <= 1'b0;
            end
        end
        if (!done) begin
            miscompares++;
            giveVerdict();
        end
    endtask

    // axi4-lite read with expected data and response
    task automatic rd(input logic [7:0] idx, input logic [7:0] e,
                      input logic [1:0] er = `GPD_RESP_OKAY);
        bit done;
        done = 0;
        @(posedge clock);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                check(rdata, {24'h0, e});
                check(rresp, er);
                done = 1;
                rready <= 1'b0;
            end
        end
        if (!done) begin
            miscompares++;
            giveVerdict();
        end
    endtask

    // main sequence
    initial begin
        tick(20);
        nrst <= 1'b1;
        tick(6);
        check(portBPullup, 8'h00);
        check(portAOe, 8'h00);
        check(extIrqFlag, 1'b0);
        rd(`GPD_IDX_A_DIR, 8'hff);
        rd(`GPD_IDX_B_DIR, 8'hff);
        rd(`GPD_IDX_OPTION, 8'hff);
        rd(`GPD_IDX_ANALOG, 8'h00);
        rd(`GPD_IDX_A_DATA, 8'he0);
        wr(`GPD_IDX_ANALOG, 8'hff);
        rd(`GPD_IDX_ANALOG, 8'hcf);
        rd(`GPD_IDX_A_DATA, 8'he0);
        wr(`GPD_IDX_ANALOG, 8'h06);
        rd(`GPD_IDX_A_DATA, 8'hff);
        wr(`GPD_IDX_A_DIR, 8'h00);
        rd(`GPD_IDX_A_DIR, 8'h20);
        wr(`GPD_IDX_A_DATA, 8'h5a);
        tick(2);
        check(portAOut, 8'h5a);
        check(portAOe, 8'hdf);
        tick(3);
        rd(`GPD_IDX_A_DATA, 8'h7a);
        wr(`GPD_IDX_A_DATA, 8'h00, 1'b0);
        tick(2);
        check(portAOut, 8'h7a);
        oscOwnsA <= 1'b1;
        tick(3);
        check(portAOe, 8'h1f);
        oscOwnsA <= 1'b0;
        wr(`GPD_IDX_OPTION, 8'h7f);
        wr(`GPD_IDX_B_DIR, 8'hf0);
        tick(2);
        check(portBPullup, 8'hf0);
        check(portBOe, 8'h0f);
        periphOwnB <= 8'h81;
        periphDirB <= 8'h01;
        tick(3);
        check(portBOe, 8'h8e);
        check(portBPullup, 8'h71);
        periphOwnB <= 8'h00;
        tick(4);
        rd(`GPD_IDX_B_DATA, 8'h00);
        wr(`GPD_IDX_INTCTL, 8'h00);
        tick(2);
        check(portChangeFlag, 1'b0);
        bExt <= 8'h80;
        tick(6);
        check(portChangeFlag, 1'b1);
        check(wakeRequest, 1'b1);
        wr(`GPD_IDX_INTCTL, 8'h00);
        tick(2);
        check(portChangeFlag, 1'b1);
        rd(`GPD_IDX_B_DATA, 8'h80);
        wr(`GPD_IDX_INTCTL, 8'h00);
        tick(2);
        check(portChangeFlag, 1'b0);
        wr(`GPD_IDX_B_DIR, 8'hff);
        rd(`GPD_IDX_B_DATA, 8'h80);
        bExt <= 8'h8e;
        tick(6);
        check(portChangeFlag, 1'b0);
        wr(`GPD_IDX_B_DIR, 8'h7f);
        tick(6);
        check(portChangeFlag, 1'b0);
        wr(`GPD_IDX_INTCTL, 8'h00);
        bExt <= 8'h8f;
        tick(6);
        check(extIrqFlag, 1'b1);
        wr(`GPD_IDX_INTCTL, 8'h00);
        wr(`GPD_IDX_OPTION, 8'h3f);
        bExt <= 8'h8e;
        tick(6);
        check(extIrqFlag, 1'b1);
        wr(`GPD_IDX_INTCTL, 8'h00);
        bExt <= 8'h8f;
        tick(6);
        check(extIrqFlag, 1'b0);
        wr(`GPD_IDX_B_DATA, 8'h00, 1'b0);
        tick(2);
        check(portBOut, 8'h0f);
        wr(`GPD_IDX_B_DIR, 8'hff);
        tick(6);
        check(portChangeFlag, 1'b1);
        wr(`GPD_IDX_B_DATA, 8'h80);
        wr(`GPD_IDX_INTCTL, 8'h00);
        tick(2);
        check(portChangeFlag, 1'b0);
        check(wakeRequest, 1'b0);
        check(portBOut, 8'h80);
        wr(8'h10, 8'h55, 1'b1, `GPD_RESP_SLVERR);
        rd(8'h10, 8'h00, `GPD_RESP_SLVERR);
        giveVerdict();
    end
endmodule

`default_nettype wire
